// file: src/deser_misc_ctl_regs.sv
`include "deser_misc_params.svh"
`default_nettype none

// Operation
// (RULE1) Port one flag sets; status read clears
// (RULE2) Port zero flag clears only by reads
// (RULE3) Frame-sync edge bit: 0 rising, 1 falling
// (RULE4) Pixel edge bit, reset 1, launch edge
// (RULE5) Five-bit low frequency limit, reset 0x14
// (RULE6) Clock below limit is judged too slow
// (RULE7) Spread-spectrum enable, reset off
// (RULE8) Software sets rate before enabling
// (RULE9) Software disables before changing rate
// (RULE10) Rate 1 selects pixel/3168, one percent
// (RULE11) Global flag: port flag and enable
// (RULE12) Per-port enables gate controller interrupt
// (RULE13) Reserved bits read reset, ignore writes
module deser_misc_ctl_regs #(
  parameter int SSC_DIV = `SSC_DIV_RATIO
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic       rx_read_port_in,
  input  wire logic       port0_event_in,
  input  wire logic       port1_event_in,
  input  wire logic       frame_sync_in,
  input  wire logic       cdr_tick_in,
  input  wire logic       pix_tick_in,
  output logic [7:0]      reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            irq_out,
  output logic            frame_sync_event_out,
  output logic            pixel_clk_edge_sel_out,
  output logic            spread_spectrum_on_out,
  output logic            spread_mod_rate_sel_out,
  output logic            freq_too_slow_out,
  output logic            ssc_active_out,
  output logic [10:0]     ssc_offset_out
);

  deser_misc_pkg::regs_state_t s_q;
  deser_misc_pkg::regs_state_t s_d;

  mon_if mon_bus ();

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Passed straight to the modulator, whose counter folds at half period
  if (SSC_DIV < 2 || SSC_DIV > 4094 || (SSC_DIV % 2) != 0)
  begin : g_bad_ssc_div
    $error("SSC_DIV must be even and within 2..4094");
  end
  // Threshold slot and stored field must agree
  if (`FREQ_LIMIT_W != $bits(s_q.freq_limit))
  begin : g_bad_limit_w
    $error("limit field width does not match its register slot");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic is_port_status(input logic [7:0] a);
    return hit(a, `ADDR_PORT_STS_A) || hit(a, `ADDR_PORT_STS_B);
  endfunction

  function automatic logic next_flag(input logic flag, input logic ev, input logic clr);
    // Set wins over a clearing read, so no event is lost
    return ev || (flag && !clr);
  endfunction

  function automatic logic global_of(input deser_misc_pkg::regs_state_t s);
    return (s.flag0 && s.ie0) || (s.flag1 && s.ie1);
  endfunction

  logic       clr0;
  logic       clr1;
  logic       global_now;
  logic       global_next;
  logic       wr;

  // ----------------------------------------
  // Register logic
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    wr  = reg_wr_in;
    // Only the port whose status block is selected for readback is cleared
    clr0 = reg_rd_in && is_port_status(reg_addr_in) && !rx_read_port_in;
    clr1 = reg_rd_in && is_port_status(reg_addr_in) && rx_read_port_in;
    global_now = global_of(s_q); // see (RULE11)

    // Writes; reserved positions are never stored
    if (wr && hit(reg_addr_in, `ADDR_IRQ_CTL))
    begin
      s_d.int_en = reg_wdata_in[`BIT_GLOBAL_IRQ];
      s_d.ie0    = reg_wdata_in[`BIT_PORT0_IRQ]; // see (RULE12)
      s_d.ie1    = reg_wdata_in[`BIT_PORT1_IRQ]; // see (RULE12)
    end
    if (wr && hit(reg_addr_in, `ADDR_FS_CFG))
      s_d.fs_edge = reg_wdata_in[`BIT_FS_EDGE]; // see (RULE3) see (RULE13)
    if (wr && hit(reg_addr_in, `ADDR_CLK_EDGE))
      s_d.pclk_edge = reg_wdata_in[`BIT_PCLK_EDGE]; // see (RULE4)
    if (wr && hit(reg_addr_in, `ADDR_FDET_CFG))
      s_d.freq_limit = reg_wdata_in[`FREQ_LIMIT_W-1:0]; // see (RULE5)
    if (wr && hit(reg_addr_in, `ADDR_SSC_CTL))
    begin
      // Both fields load together; ordering is left to software
      s_d.ssc_on   = reg_wdata_in[`BIT_SSC_ON]; // see (RULE7) see (RULE8) see (RULE9)
      s_d.ssc_rate = reg_wdata_in[`BIT_SSC_RATE]; // see (RULE10)
    end

    // Flags: a new event wins over a clearing read; writes never touch them
    s_d.flag0 = next_flag(s_q.flag0, port0_event_in, clr0); // see (RULE2)
    s_d.flag1 = next_flag(s_q.flag1, port1_event_in, clr1); // see (RULE1)

    global_next = global_of(s_d); // see (RULE11)
    s_d.irq     = global_next && s_d.int_en; // see (RULE12)

    // Frame-sync active edge detect
    s_d.fs_prev  = frame_sync_in;
    s_d.fs_event = s_q.fs_edge ? (s_q.fs_prev && !frame_sync_in)
                               : (!s_q.fs_prev && frame_sync_in); // see (RULE3)

    // Read data, one cycle after the strobe
    s_d.rvalid = reg_rd_in;
    s_d.rdata  = 8'h00;
    if (reg_rd_in)
    begin
      // Reserved positions keep the preset zero
      unique case (reg_addr_in)
        `ADDR_IRQ_CTL:
        begin
          s_d.rdata[`BIT_GLOBAL_IRQ] = s_q.int_en;
          s_d.rdata[`BIT_PORT1_IRQ]  = s_q.ie1;
          s_d.rdata[`BIT_PORT0_IRQ]  = s_q.ie0;
        end
        `ADDR_IRQ_STS:
        begin
          s_d.rdata[`BIT_GLOBAL_IRQ] = global_now; // see (RULE11)
          s_d.rdata[`BIT_PORT1_IRQ]  = s_q.flag1; // see (RULE1)
          s_d.rdata[`BIT_PORT0_IRQ]  = s_q.flag0; // see (RULE2)
        end
        `ADDR_FS_CFG:
          s_d.rdata[`BIT_FS_EDGE] = s_q.fs_edge; // see (RULE3)
        `ADDR_CLK_EDGE:
          s_d.rdata[`BIT_PCLK_EDGE] = s_q.pclk_edge; // see (RULE4)
        `ADDR_FDET_CFG:
          s_d.rdata[`FREQ_LIMIT_W-1:0] = s_q.freq_limit; // see (RULE5)
        `ADDR_SSC_CTL:
        begin
          s_d.rdata[`BIT_SSC_ON]   = s_q.ssc_on;
          s_d.rdata[`BIT_SSC_RATE] = s_q.ssc_rate;
        end
        default:
          s_d.rdata = 8'h00; // see (RULE13)
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q            <= '0;
      s_q.fs_edge    <= `RST_FS_EDGE;
      s_q.pclk_edge  <= `RST_PCLK_EDGE;
      s_q.freq_limit <= `RST_FREQ_LIMIT;
      s_q.ssc_on     <= `RST_SSC_ON;
      s_q.ssc_rate   <= `RST_SSC_RATE;
      s_q.ie0        <= `RST_IRQ_EN;
      s_q.ie1        <= `RST_IRQ_EN;
      s_q.int_en     <= `RST_IRQ_EN;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Clock monitor
  // ----------------------------------------
  assign mon_bus.low_limit = s_q.freq_limit;
  assign mon_bus.ssc_on    = s_q.ssc_on;
  assign mon_bus.ssc_rate  = s_q.ssc_rate;

  clk_monitor #(
    .SSC_DIV (SSC_DIV)
  ) u_mon (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .cdr_tick_in (cdr_tick_in),
    .pix_tick_in (pix_tick_in),
    .mon         (mon_bus.mon)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out           = s_q.rdata;
  assign reg_rvalid_out          = s_q.rvalid;
  assign irq_out                 = s_q.irq;
  assign frame_sync_event_out    = s_q.fs_event;
  assign pixel_clk_edge_sel_out  = s_q.pclk_edge; // see (RULE4)
  assign spread_spectrum_on_out  = s_q.ssc_on;
  assign spread_mod_rate_sel_out = s_q.ssc_rate;
  assign freq_too_slow_out       = mon_bus.too_slow; // see (RULE6)
  assign ssc_active_out          = mon_bus.ssc_active;
  assign ssc_offset_out          = mon_bus.ssc_tri;

endmodule // deser_misc_ctl_regs

`default_nettype wire

// file: src/deser_misc_params.svh
`ifndef DESER_MISC_PARAMS_SVH
`define DESER_MISC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_IRQ_CTL       8'h23
`define ADDR_IRQ_STS       8'h24
`define ADDR_FS_CFG        8'h25
`define ADDR_CLK_EDGE      8'h3b
`define ADDR_FDET_CFG      8'h3c
`define ADDR_SSC_CTL       8'h3e
`define ADDR_PORT_STS_A    8'h4d
`define ADDR_PORT_STS_B    8'h4e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PORT0_IRQ      0
`define BIT_PORT1_IRQ      1
`define BIT_GLOBAL_IRQ     7
`define BIT_FS_EDGE        6
`define BIT_PCLK_EDGE      0
`define BIT_SSC_ON         4
`define BIT_SSC_RATE       0
`define FREQ_LIMIT_W       5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FS_EDGE        1'h0
`define RST_PCLK_EDGE      1'h1
`define RST_FREQ_LIMIT     5'h14
`define RST_SSC_ON         1'h0
`define RST_SSC_RATE       1'h0
`define RST_IRQ_EN         1'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      40
`define FDET_WINDOW_NS     1000
`define FDET_WINDOW_CYC    ((`FDET_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SSC_DIV_RATIO      3168
`define SSC_DEV_PERCENT    1

`endif

// file: src/deser_misc_pkg.sv
`default_nettype none

package deser_misc_pkg;

  typedef struct packed {
    logic [7:0]  win_cnt;
    logic [7:0]  tick_cnt;
    logic        too_slow;
    logic [11:0] ssc_cnt;
    logic        ssc_active;
    logic [10:0] ssc_tri;
  } mon_state_t;

  typedef struct packed {
    logic       fs_edge;
    logic       pclk_edge;
    logic [4:0] freq_limit;
    logic       ssc_on;
    logic       ssc_rate;
    logic       ie0;
    logic       ie1;
    logic       int_en;
    logic       flag0;
    logic       flag1;
    logic       fs_prev;
    logic       fs_event;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } regs_state_t;

endpackage

`default_nettype wire

// file: src/mon_if.sv
`default_nettype none

interface mon_if;
  logic [4:0]  low_limit;
  logic        ssc_on;
  logic        ssc_rate;
  logic        too_slow;
  logic        ssc_active;
  logic [10:0] ssc_tri;

  modport regs (output low_limit, ssc_on, ssc_rate, input too_slow, ssc_active, ssc_tri);
  modport mon  (input low_limit, ssc_on, ssc_rate, output too_slow, ssc_active, ssc_tri);
endinterface

`default_nettype wire

// file: src/clk_monitor.sv
`include "deser_misc_params.svh"
`default_nettype none

module clk_monitor #(
  parameter int SSC_DIV = `SSC_DIV_RATIO
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic cdr_tick_in,
  input  wire logic pix_tick_in,
  mon_if.mon        mon
);

  localparam logic [7:0]  WIN_LAST = 8'(`FDET_WINDOW_CYC - 1);
  localparam logic [11:0] DIV_LAST = 12'(SSC_DIV - 1);
  localparam logic [11:0] DIV_HALF = 12'(SSC_DIV / 2);

  if (SSC_DIV < 2 || SSC_DIV > 4094 || (SSC_DIV % 2) != 0)
  begin : g_bad_div
    $error("SSC_DIV must be even and within 2..4094");
  end
  // Window counter is eight bits wide
  if (`FDET_WINDOW_CYC < 2 || `FDET_WINDOW_CYC > 256)
  begin : g_bad_win
    $error("frequency window must span 2..256 cycles");
  end

  deser_misc_pkg::mon_state_t s_q;
  deser_misc_pkg::mon_state_t s_d;

  // ----------------------------------------
  // Frequency detector and modulator
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Saturate so a very fast clock never wraps into looking slow
    if (cdr_tick_in && s_q.tick_cnt != 8'hff)
      s_d.tick_cnt = s_q.tick_cnt + 8'h01;
    if (s_q.win_cnt == WIN_LAST)
    begin
      s_d.win_cnt  = 8'h00;
      s_d.too_slow = (s_q.tick_cnt < {3'h0, mon.low_limit}); // see (RULE6)
      s_d.tick_cnt = {7'h00, cdr_tick_in};
    end
    else
      s_d.win_cnt = s_q.win_cnt + 8'h01;
    // Rate value zero is reserved: modulation stays off
    s_d.ssc_active = mon.ssc_on && mon.ssc_rate; // see (RULE7) see (RULE10)
    if (!s_d.ssc_active)
      s_d.ssc_cnt = 12'h000;
    else if (pix_tick_in)
      s_d.ssc_cnt = (s_q.ssc_cnt == DIV_LAST) ? 12'h000 : s_q.ssc_cnt + 12'h001; // see (RULE10)
    s_d.ssc_tri = (s_q.ssc_cnt < DIV_HALF) ? s_q.ssc_cnt[10:0]
                                           : 11'(DIV_LAST - s_q.ssc_cnt);
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign mon.too_slow   = s_q.too_slow;
  assign mon.ssc_active = s_q.ssc_active;
  assign mon.ssc_tri    = s_q.ssc_tri;

endmodule // clk_monitor

`default_nettype wire

// file: sim/deser_misc_ctl_regs_checker.sv
`default_nettype none

// ----------------------------------------
// Port checks
// ----------------------------------------
module deser_misc_ctl_regs_checker (
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic       rx_read_port_in,
  input wire logic       port0_event_in,
  input wire logic       port1_event_in,
  input wire logic       frame_sync_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       irq_out,
  input wire logic       frame_sync_event_out,
  input wire logic       pixel_clk_edge_sel_out,
  input wire logic       spread_spectrum_on_out,
  input wire logic       spread_mod_rate_sel_out,
  input wire logic       ssc_active_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Shadow of the edge select, the bit itself is not a port
  logic fs_sel_q;
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      fs_sel_q <= 1'b0;
    else if (reg_wr_in && reg_addr_in == 8'h25)
      fs_sel_q <= reg_wdata_in[6];
  sequence s_fs_edge;
    (frame_sync_in == fs_sel_q) ##1 (frame_sync_in != fs_sel_q && $stable(fs_sel_q));
  endsequence
  sequence s_clr1;
    (reg_rd_in && reg_addr_in == 8'h4d && rx_read_port_in && !port1_event_in)
      ##1 !port1_event_in ##1 (reg_rd_in && reg_addr_in == 8'h24 && !port1_event_in);
  endsequence
  sequence s_ev0;
    port0_event_in
      ##1 !(reg_rd_in && !rx_read_port_in && (reg_addr_in == 8'h4d || reg_addr_in == 8'h4e))
      ##1 (reg_rd_in && reg_addr_in == 8'h24);
  endsequence
  sequence s_lim;
    (reg_wr_in && reg_addr_in == 8'h3c) ##2 (reg_rd_in && reg_addr_in == 8'h3c);
  endsequence
  property p_rvalid;
    reg_rvalid_out == $past(reg_rd_in);
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read valid not one cycle after strobe");
  property p_fs;
    s_fs_edge |-> ##[0:2] frame_sync_event_out;
  endproperty
  a_fs: assert property (p_fs)
    else $error("frame sync event missing");
  property p_pclk;
    reg_wr_in && reg_addr_in == 8'h3b |=> pixel_clk_edge_sel_out == $past(reg_wdata_in[0]);
  endproperty
  a_pclk: assert property (p_pclk)
    else $error("pixel edge select not loaded");
  property p_lim;
    s_lim |=> reg_rdata_out == {3'h0, $past(reg_wdata_in[4:0], 3)};
  endproperty
  a_lim: assert property (p_lim)
    else $error("low limit readback wrong");
  property p_on;
    reg_wr_in && reg_addr_in == 8'h3e |=> spread_spectrum_on_out == $past(reg_wdata_in[4]);
  endproperty
  a_on: assert property (p_on)
    else $error("spread enable not loaded");
  property p_act;
    ssc_active_out == $past(spread_spectrum_on_out && spread_mod_rate_sel_out);
  endproperty
  a_act: assert property (p_act)
    else $error("modulation active wrong");
  property p_clr1;
    s_clr1 |=> !reg_rdata_out[1];
  endproperty
  a_clr1: assert property (p_clr1)
    else $error("port one flag not cleared");
  property p_ev0;
    s_ev0 |=> reg_rdata_out[0];
  endproperty
  a_ev0: assert property (p_ev0)
    else $error("port zero flag not set");
  property p_irq;
    $rose(irq_out) |-> $past(port0_event_in || port1_event_in || reg_wr_in);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt rose without cause");
  property p_rsv;
    reg_rd_in && reg_addr_in == 8'h3e |=> reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[3:1] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits not zero");
endmodule // deser_misc_ctl_regs_checker

bind deser_misc_ctl_regs deser_misc_ctl_regs_checker deser_misc_ctl_regs_checker_inst (
  .clock_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .rx_read_port_in, .port0_event_in, .port1_event_in, .frame_sync_in,
  .reg_rdata_out, .reg_rvalid_out, .irq_out, .frame_sync_event_out,
  .pixel_clk_edge_sel_out, .spread_spectrum_on_out, .spread_mod_rate_sel_out,
  .ssc_active_out
);

`default_nettype wire

// file: sim/testbench.sv
`default_nettype none

// ----------------------------------------
// Bench
// ----------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in        = 1'b0;
  logic        rst_in          = 1'b1;
  logic [7:0]  reg_addr_in     = 8'h00;
  logic [7:0]  reg_wdata_in    = 8'h00;
  logic        reg_wr_in       = 1'b0;
  logic        reg_rd_in       = 1'b0;
  logic        rx_read_port_in = 1'b0;
  logic        port0_event_in  = 1'b0;
  logic        port1_event_in  = 1'b0;
  logic        frame_sync_in   = 1'b0;
  logic        cdr_tick_in     = 1'b0;
  logic        pix_tick_in     = 1'b0;
  logic [10:0] fs_cnt          = 11'h0;
  logic [7:0]  reg_rdata_out;
  logic [10:0] ssc_offset_out;
  logic        reg_rvalid_out, irq_out, frame_sync_event_out, pixel_clk_edge_sel_out;
  logic        spread_spectrum_on_out, spread_mod_rate_sel_out, freq_too_slow_out;
  logic        ssc_active_out;
  int          failures = 0;
  int          comparisons = 0;

  deser_misc_ctl_regs #(.SSC_DIV(8)) deser_misc_ctl_regs_inst (
    .clock_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .rx_read_port_in, .port0_event_in, .port1_event_in, .frame_sync_in,
    .cdr_tick_in, .pix_tick_in, .reg_rdata_out, .reg_rvalid_out, .irq_out,
    .frame_sync_event_out, .pixel_clk_edge_sel_out, .spread_spectrum_on_out,
    .spread_mod_rate_sel_out, .freq_too_slow_out, .ssc_active_out, .ssc_offset_out
  );

  initial forever #20 clock_in = ~clock_in;
  // Ticks every other cycle keep them sparse
  always @(negedge clock_in)
  begin
    cdr_tick_in <= ~cdr_tick_in;
    pix_tick_in <= ~pix_tick_in;
    if (frame_sync_event_out === 1'b1)
      fs_cnt <= fs_cnt + 11'h1;
  end

  task automatic chk(string n, logic [10:0] s, logic [10:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    chk($sformatf("reg %h", a), {2'h0, reg_rvalid_out, reg_rdata_out}, {3'h1, e});
  endtask
  task automatic ev(logic p);
    @(negedge clock_in);
    port0_event_in = ~p;
    port1_event_in = p;
    @(negedge clock_in);
    port0_event_in = 1'b0;
    port1_event_in = 1'b0;
  endtask
  task automatic fsp(logic v);
    @(negedge clock_in);
    frame_sync_in = v;
    repeat (4) @(negedge clock_in);
  endtask
  task automatic t_reset;
    chk("pclk", 11'(pixel_clk_edge_sel_out), 11'h1);
    rd(8'h25, 8'h00);
    rd(8'h3b, 8'h01);
    rd(8'h3c, 8'h14);
    rd(8'h3e, 8'h00);
    rd(8'h23, 8'h00);
  endtask
  task automatic t_regs;
    wr(8'h3b, 8'hfe);
    rd(8'h3b, 8'h00);
    chk("pclk", 11'(pixel_clk_edge_sel_out), 11'h0);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h1f);
    wr(8'h24, 8'hff);
    rd(8'h24, 8'h00);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
  endtask
  task automatic t_fs;
    wr(8'h25, 8'hbf);
    rd(8'h25, 8'h00);
    fs_cnt = 11'h0;
    fsp(1'b1);
    chk("fs rise", fs_cnt, 11'h1);
    fsp(1'b0);
    chk("fs fall", fs_cnt, 11'h1);
    wr(8'h25, 8'hff);
    rd(8'h25, 8'h40);
    fs_cnt = 11'h0;
    fsp(1'b1);
    chk("fs rise", fs_cnt, 11'h0);
    fsp(1'b0);
    chk("fs fall", fs_cnt, 11'h1);
  endtask
  task automatic t_ssc;
    wr(8'h3e, 8'h01);
    chk("rate", 11'(spread_mod_rate_sel_out), 11'h1);
    chk("act", 11'(ssc_active_out), 11'h0);
    wr(8'h3e, 8'h11);
    chk("on", 11'(spread_spectrum_on_out), 11'h1);
    repeat (6) @(negedge clock_in);
    chk("act", 11'(ssc_active_out), 11'h1);
    chk("move", 11'(ssc_offset_out != 11'h0), 11'h1);
    wr(8'h3e, 8'h01);
    repeat (2) @(negedge clock_in);
    chk("off", ssc_offset_out, 11'h0);
    wr(8'h3e, 8'he0);
    rd(8'h3e, 8'h00);
    wr(8'h3e, 8'hfe);
    rd(8'h3e, 8'h10);
    chk("act", 11'(ssc_active_out), 11'h0);
  endtask
  task automatic t_irq;
    wr(8'h23, 8'h83);
    ev(1'b1);
    rd(8'h24, 8'h82);
    chk("irq", 11'(irq_out), 11'h1);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'h82);
    rd(8'h4d, 8'h00);
    rd(8'h24, 8'h82);
    rx_read_port_in = 1'b1;
    rd(8'h4d, 8'h00);
    rd(8'h24, 8'h00);
    wr(8'h23, 8'h02);
    ev(1'b0);
    rd(8'h24, 8'h01);
    wr(8'h23, 8'h01);
    rd(8'h24, 8'h81);
    chk("irq", 11'(irq_out), 11'h0);
    rd(8'h4e, 8'h00);
    rd(8'h24, 8'h81);
    rx_read_port_in = 1'b0;
    rd(8'h4e, 8'h00);
    rd(8'h24, 8'h00);
  endtask
  task automatic t_freq;
    wr(8'h3c, 8'h05);
    repeat (60) @(negedge clock_in);
    chk("slow", 11'(freq_too_slow_out), 11'h0);
    wr(8'h3c, 8'h1f);
    repeat (60) @(negedge clock_in);
    chk("slow", 11'(freq_too_slow_out), 11'h1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    t_reset;
    t_regs;
    t_fs;
    t_ssc;
    t_irq;
    t_freq;
    wrap_up;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clock_in);
    failures++;
    wrap_up;
  end
endmodule // testbench

`default_nettype wire
